// File: dcp_pkg.sv
// shared constants for the down counter / dead-band block and its controller
// ----------------------------------------------------------------------------
// Behaviour
// - 8-bit down counter, cascadable in bytes
// - enable low holds; at terminal count, reload once
// - reload period the cycle after zero
// - disabled period write also loads count
// - count read returns zero; while disabled it also copies count to compare
// - software reads count byte then compare byte
// - decrement on source rising edge while enabled
// - compare output on falling edge, less/less-equal
// - interrupt on terminal count or compare rise
// - count enable synchronous; external enable synchronised
// - disabled: clock stops, outputs low, count kept
// - dead-band: lead/lag outputs never both high
// - edge drops one output, dead time, other rises
// - dead-band counter not cascadable, 256 ticks
// - dead count reloads on each input edge
// - dead-band input wired from previous primary output; here driven by the controller CTL_WAVE bit
// - kill holds both outputs low, synchronised
// - dead-band interrupt on lead_output rising edge
// - dead time is tick times one plus period
// - enable modulator before dead-band block
// - restart: kill, disable, write period, release, enable
// ----------------------------------------------------------------------------
package dcp_pkg;

    // ------------------------------------------------------------------------
    // block register port
    // ------------------------------------------------------------------------
    localparam logic [2:0] REG_COUNT   = 3'h0;
    localparam logic [2:0] REG_PERIOD  = 3'h1;
    localparam logic [2:0] REG_COMPARE = 3'h2;
    localparam logic [2:0] REG_CONTROL = 3'h3;
    localparam logic [2:0] REG_FUNC    = 3'h4;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int FUNC_IRQ_SEL    = 0;
    localparam int FUNC_LESS_EQ    = 1;
    localparam int FUNC_DEADBAND   = 2;
    localparam int FUNC_EXT_ENABLE = 3;
    localparam int FUNC_EXT_KILL   = 4;

    localparam logic [7:0] COUNT_RST   = 8'h00;
    localparam logic [7:0] PERIOD_RST  = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'h00;
    localparam logic [4:0] FUNC_RST    = 5'h00;

    // ------------------------------------------------------------------------
    // controller apb map
    // ------------------------------------------------------------------------
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_DIV  = 8'h04;
    localparam logic [7:0] APB_CMD  = 8'h08;
    localparam logic [7:0] APB_STAT = 8'h0c;

    localparam int CTL_SRC_RUN  = 0;
    localparam int CTL_CNT_EN   = 1;
    localparam int CTL_KILL     = 2;
    localparam int CTL_WAVE     = 3;
    localparam int CTL_CHAIN_IN = 4;
    localparam logic [4:0] CTL_RST = 5'h10;
    localparam logic [7:0] DIV_RST = 8'h00;

    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_WRITE    = 11;

    localparam int STAT_RDATA_LSB = 0;
    localparam int STAT_LEAD      = 8;
    localparam int STAT_LAG       = 9;
    localparam int STAT_CMP       = 10;
    localparam int STAT_TC        = 11;
    localparam int STAT_IRQ       = 12;
    localparam int STAT_CHAIN_OUT = 13;
    localparam int STAT_IRQ_SEEN  = 14;

    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        DCP_LAG_ON    = 2'b00,
        DCP_DEAD_RISE = 2'b01,
        DCP_LEAD_ON   = 2'b11,
        DCP_DEAD_FALL = 2'b10
    } dcp_db_state_t;

endpackage

// File: dcp_if.sv
// link between the counter block and its controller
interface dcp_if;
    logic       src_clk;
    logic       cnt_en;
    logic       kill;
    logic       wave_in;
    logic       chain_in;
    logic [2:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       lead_output;
    logic       lag_output;
    logic       cmp_out;
    logic       tc_out;
    logic       chain_out;
    logic       irq;

    modport block (
        input  src_clk, cnt_en, kill, wave_in, chain_in,
        input  reg_addr, reg_wr, reg_rd, reg_wdata,
        output reg_rdata, lead_output, lag_output, cmp_out, tc_out,
        output chain_out, irq
    );
    modport ctrl (
        output src_clk, cnt_en, kill, wave_in, chain_in,
        output reg_addr, reg_wr, reg_rd, reg_wdata,
        input  reg_rdata, lead_output, lag_output, cmp_out, tc_out,
        input  chain_out, irq
    );
endinterface

// File: dcp_block.sv
// down counter / pulse-width modulator and dead-band generator block
//
// The implementer's own choices: the register offsets and the APB register port.
module dcp_block (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ext_enable,
    input  wire logic ext_kill,
    dcp_if.block      bus
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0]              count;
    logic [7:0]              period;
    logic [7:0]              compare;
    logic                    enabled;
    logic [4:0]              func;
    logic [7:0]              rdata;
    logic                    src_q;
    logic                    en_prev;
    logic                    cmp_q;
    logic                    lead_q;
    logic                    lag_q;
    logic                    irq_src_q;
    logic                    irq_q;
    logic [2:0]              en_sync;
    logic [2:0]              kill_sync;
    logic                    en_ext_f;
    logic                    kill_ext_f;
    dcp_pkg::dcp_db_state_t  db_state;
    dcp_pkg::dcp_db_state_t  next_db_state;
    logic                    wave_q;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    wire db_mode   = func[dcp_pkg::FUNC_DEADBAND];
    wire le_mode   = func[dcp_pkg::FUNC_LESS_EQ];
    wire irq_sel   = func[dcp_pkg::FUNC_IRQ_SEL];
    wire src_rise  = enabled & bus.src_clk & ~src_q;
    wire src_fall  = enabled & ~bus.src_clk & src_q;
    wire cnt_en    = func[dcp_pkg::FUNC_EXT_ENABLE] ? en_ext_f : bus.cnt_en;
    wire kill      = func[dcp_pkg::FUNC_EXT_KILL] ? kill_ext_f : bus.kill;
    wire at_zero   = (count == 8'h00);
    wire tc        = at_zero & bus.chain_in;
    wire wr_count  = bus.reg_wr & (bus.reg_addr == dcp_pkg::REG_COUNT);
    wire wr_period = bus.reg_wr & (bus.reg_addr == dcp_pkg::REG_PERIOD);
    wire wr_cmp    = bus.reg_wr & (bus.reg_addr == dcp_pkg::REG_COMPARE);
    wire wr_ctrl   = bus.reg_wr & (bus.reg_addr == dcp_pkg::REG_CONTROL);
    wire wr_func   = bus.reg_wr & (bus.reg_addr == dcp_pkg::REG_FUNC);
    wire rd_count  = bus.reg_rd & (bus.reg_addr == dcp_pkg::REG_COUNT);
    wire snap      = rd_count & ~enabled;
    wire cmp_now   = le_mode ? (count <= compare) : (count < compare);
    wire wave_rise = bus.wave_in & ~wave_q;
    wire wave_fall = ~bus.wave_in & wave_q;
    wire wave_edge = enabled & db_mode & (wave_rise | wave_fall);

    // counter step on a source rising edge
    wire cnt_go    = src_rise & ~db_mode & bus.chain_in &
                     (cnt_en | (tc & en_prev));
    wire db_run    = (db_state == dcp_pkg::DCP_DEAD_RISE) |
                     (db_state == dcp_pkg::DCP_DEAD_FALL);
    wire db_go     = src_rise & db_mode & db_run & ~wave_edge;
    wire db_done   = db_go & at_zero;

    wire irq_src   = db_mode ? lead_q : (irq_sel ? cmp_q : tc);
    wire irq_rise  = enabled & irq_src & ~irq_src_q;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_sync    <= 3'h0;
            kill_sync  <= 3'h0;
            en_ext_f   <= 1'b0;
            kill_ext_f <= 1'b0;
        end else begin
            en_sync   <= {en_sync[1:0], ext_enable};
            kill_sync <= {kill_sync[1:0], ext_kill};
            if (en_sync[1] == en_sync[2]) begin
                en_ext_f <= en_sync[2];
            end
            if (kill_sync[1] == kill_sync[2]) begin
                kill_ext_f <= kill_sync[2];
            end
        end
    end

    // ------------------------------------------------------------------------
    // register port and counter
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count   <= dcp_pkg::COUNT_RST;
            period  <= dcp_pkg::PERIOD_RST;
            compare <= dcp_pkg::COMPARE_RST;
            enabled <= 1'b0;
            func    <= dcp_pkg::FUNC_RST;
            rdata   <= 8'h00;
            src_q   <= 1'b0;
            en_prev <= 1'b0;
        end else begin
            src_q <= bus.src_clk;
            if (src_rise) begin
                en_prev <= cnt_en;
            end
            if (wr_period) begin
                period <= bus.reg_wdata;
            end
            if (wr_ctrl) begin
                enabled <= bus.reg_wdata[dcp_pkg::CTRL_ENABLE_BIT];
            end
            if (wr_func) begin
                func <= bus.reg_wdata[4:0];
            end
            if (snap) begin
                compare <= count;
            end else if (wr_cmp) begin
                compare <= bus.reg_wdata;
            end
            if (bus.reg_rd) begin
                unique case (bus.reg_addr)
                    dcp_pkg::REG_PERIOD:  rdata <= period;
                    dcp_pkg::REG_COMPARE: rdata <= compare;
                    dcp_pkg::REG_CONTROL: rdata <= {7'h00, enabled};
                    dcp_pkg::REG_FUNC:    rdata <= {3'h0, func};
                    default:              rdata <= 8'h00;
                endcase
            end
            if (wr_period && !enabled) begin
                count <= bus.reg_wdata;
            end else if (wr_count && !enabled) begin
                count <= bus.reg_wdata;
            end else if (wave_edge) begin
                count <= period;
            end else if (cnt_go) begin
                count <= tc ? period : count - 8'h01;
            end else if (db_go && !at_zero) begin
                count <= count - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // dead-band sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        next_db_state = db_state;
        if (wave_edge) begin
            next_db_state = wave_rise ? dcp_pkg::DCP_DEAD_RISE
                                      : dcp_pkg::DCP_DEAD_FALL;
        end else if (db_done) begin
            next_db_state = (db_state == dcp_pkg::DCP_DEAD_RISE)
                          ? dcp_pkg::DCP_LEAD_ON : dcp_pkg::DCP_LAG_ON;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_state <= dcp_pkg::DCP_DEAD_FALL;
            wave_q   <= 1'b0;
        end else begin
            wave_q   <= bus.wave_in;
            db_state <= next_db_state;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q     <= 1'b0;
            lead_q    <= 1'b0;
            lag_q     <= 1'b0;
            irq_src_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            if (!enabled || db_mode) begin
                cmp_q <= 1'b0;
            end else if (src_fall) begin
                cmp_q <= cmp_now;
            end
            // lead and lag come from one state, so they never overlap
            lead_q <= enabled & db_mode & ~kill &
                      (next_db_state == dcp_pkg::DCP_LEAD_ON);
            lag_q  <= enabled & db_mode & ~kill &
                      (next_db_state == dcp_pkg::DCP_LAG_ON);
            irq_src_q <= irq_src;
            irq_q     <= irq_rise;
        end
    end

    assign bus.reg_rdata   = rdata;
    assign bus.cmp_out     = cmp_q;
    assign bus.tc_out      = enabled & ~db_mode & tc;
    assign bus.chain_out   = bus.tc_out;
    assign bus.lead_output = lead_q;
    assign bus.lag_output  = lag_q;
    assign bus.irq         = irq_q;

endmodule

// File: dcp_ctrl.sv
// apb controller that drives the counter block and its neighbour signals
module dcp_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    dcp_if.ctrl              bus
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [4:0] ctl;
    logic [7:0] div;
    logic [7:0] div_cnt;
    logic       src;
    logic [2:0] cmd_addr;
    logic [7:0] cmd_data;
    logic       cmd_wr;
    logic       cmd_rd;
    logic       rd_wait;
    logic [7:0] last_rdata;
    logic       irq_seen;

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    wire access   = psel & penable;
    wire wr_ctl   = access & pwrite & (paddr == dcp_pkg::APB_CTRL);
    wire wr_div   = access & pwrite & (paddr == dcp_pkg::APB_DIV);
    wire wr_cmd   = access & pwrite & (paddr == dcp_pkg::APB_CMD);
    wire rd_stat  = access & ~pwrite & (paddr == dcp_pkg::APB_STAT);
    wire div_tick = ctl[dcp_pkg::CTL_SRC_RUN] & (div_cnt == div);

    wire [31:0] stat_word = {17'h0, irq_seen, bus.chain_out, bus.irq,
                             bus.tc_out, bus.cmp_out, bus.lag_output,
                             bus.lead_output, last_rdata};
    wire [31:0] rd_mux =
        (paddr == dcp_pkg::APB_CTRL) ? {27'h0, ctl} :
        (paddr == dcp_pkg::APB_DIV)  ? {24'h0, div} :
        (paddr == dcp_pkg::APB_STAT) ? stat_word : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // ------------------------------------------------------------------------
    // apb registers, command pulse, read capture
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl        <= dcp_pkg::CTL_RST;
            div        <= dcp_pkg::DIV_RST;
            cmd_addr   <= 3'h0;
            cmd_data   <= 8'h00;
            cmd_wr     <= 1'b0;
            cmd_rd     <= 1'b0;
            rd_wait    <= 1'b0;
            last_rdata <= 8'h00;
            prdata     <= 32'h0;
            irq_seen   <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl <= pwdata[4:0];
            end
            if (wr_div) begin
                div <= pwdata[7:0];
            end
            cmd_wr <= wr_cmd & pwdata[dcp_pkg::CMD_WRITE];
            cmd_rd <= wr_cmd & ~pwdata[dcp_pkg::CMD_WRITE];
            if (wr_cmd) begin
                cmd_addr <= pwdata[dcp_pkg::CMD_ADDR_LSB +: 3];
                cmd_data <= pwdata[dcp_pkg::CMD_DATA_LSB +: 8];
            end
            rd_wait <= cmd_rd;
            if (rd_wait) begin
                last_rdata <= bus.reg_rdata;
            end
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
            // a new interrupt pulse wins over the clearing read
            if (bus.irq) begin
                irq_seen <= 1'b1;
            end else if (rd_stat) begin
                irq_seen <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // source clock divider
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 8'h00;
            src     <= 1'b0;
        end else if (!ctl[dcp_pkg::CTL_SRC_RUN]) begin
            div_cnt <= 8'h00;
        end else if (div_tick) begin
            div_cnt <= 8'h00;
            src     <= ~src;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign bus.src_clk   = src;
    assign bus.cnt_en    = ctl[dcp_pkg::CTL_CNT_EN];
    assign bus.kill      = ctl[dcp_pkg::CTL_KILL];
    assign bus.wave_in   = ctl[dcp_pkg::CTL_WAVE];
    assign bus.chain_in  = ctl[dcp_pkg::CTL_CHAIN_IN];
    assign bus.reg_addr  = cmd_addr;
    assign bus.reg_wdata = cmd_data;
    assign bus.reg_wr    = cmd_wr;
    assign bus.reg_rd    = cmd_rd;

endmodule

// File: dcp_asserts.sv
// concurrent checks on the link between the counter block and its controller
module dcp_asserts (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       src_clk,
    input wire logic       cnt_en,
    input wire logic       kill,
    input wire logic       wave_in,
    input wire logic       chain_in,
    input wire logic [2:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       lead_output,
    input wire logic       lag_output,
    input wire logic       cmp_out,
    input wire logic       tc_out,
    input wire logic       chain_out,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // shadow of the block enable and function settings
    // ------------------------------------------------------------------------
    logic       en_q;
    logic [4:0] func_q;
    wire        db_mode  = func_q[dcp_pkg::FUNC_DEADBAND];
    wire        ext_en   = func_q[dcp_pkg::FUNC_EXT_ENABLE];
    wire        ext_kl   = func_q[dcp_pkg::FUNC_EXT_KILL];
    wire        wr_ctl   = reg_wr && (reg_addr == dcp_pkg::REG_CONTROL);
    wire        wr_func  = reg_wr && (reg_addr == dcp_pkg::REG_FUNC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q   <= 1'b0;
            func_q <= dcp_pkg::FUNC_RST;
        end else begin
            if (wr_ctl) en_q <= reg_wdata[dcp_pkg::CTRL_ENABLE_BIT];
            if (wr_func) func_q <= reg_wdata[4:0];
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    no_overlap_a: assert property (!(lead_output && lag_output))
        else $error("lead and lag high together");
    chain_match_a: assert property (chain_out == tc_out)
        else $error("cascade carry differs from terminal count");
    tc_mode_a: assert property (tc_out |-> en_q && !db_mode && chain_in)
        else $error("terminal count outside enabled counter mode");
    off_quiet_a: assert property (!en_q ##1 !en_q |->
        !lead_output && !lag_output && !cmp_out && !tc_out && !irq)
        else $error("output active while block disabled");
    irq_pulse_a: assert property (irq |=> !irq)
        else $error("interrupt longer than one cycle");
    tc_step_a: assert property ($rose(tc_out) && $past(en_q) |->
        $past(src_clk) || $past(src_clk, 2))
        else $error("count reached zero without a source rise");
    tc_enable_a: assert property (
        $rose(tc_out) && $past(en_q) && !ext_en |-> $past(cnt_en))
        else $error("count moved while enable low");
    cmp_fall_a: assert property (
        $changed(cmp_out) && en_q && $past(en_q) |-> !src_clk)
        else $error("compare output moved outside source low phase");
    kill_gate_a: assert property (
        (kill && !ext_kl) ##1 (kill && !ext_kl)
        |-> !lead_output && !lag_output)
        else $error("output high while kill asserted");
    lag_drop_a: assert property (
        $rose(wave_in) && en_q && db_mode && !kill |-> ##[1:3] !lag_output)
        else $error("lag output not dropped after input rise");
    lead_irq_a: assert property (
        $rose(lead_output) && db_mode |-> $past(irq) or ##[0:2] irq)
        else $error("no interrupt on lead output rise");
endmodule

// File: tb_down_counter_pwm_deadband.sv
// self-checking bench: apb controller driving the counter / dead-band block
module tb_down_counter_pwm_deadband;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         LIMIT = 20000;
    localparam logic [4:0] FUNCS [5] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08};

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_enable;
    logic        ext_kill;
    logic [31:0] rd;
    logic [7:0]  b;
    logic [3:0]  seen;
    int          fail_count;
    int          checks;
    int          cycles;

    dcp_if link ();
    dcp_block i_dcp_block (.pclk(pclk), .presetn(presetn),
        .ext_enable(ext_enable), .ext_kill(ext_kill), .bus(link));
    dcp_ctrl i_dcp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
    dcp_asserts u_chk (.pclk(pclk), .presetn(presetn),
        .src_clk(link.src_clk), .cnt_en(link.cnt_en), .kill(link.kill),
        .wave_in(link.wave_in), .chain_in(link.chain_in),
        .reg_addr(link.reg_addr), .reg_wr(link.reg_wr),
        .reg_wdata(link.reg_wdata), .lead_output(link.lead_output),
        .lag_output(link.lag_output), .cmp_out(link.cmp_out),
        .tc_out(link.tc_out), .chain_out(link.chain_out), .irq(link.irq));

    always #5 pclk = ~pclk;

    // ------------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------------
    task automatic report_and_stop();
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] q);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic blk_wr(input logic [2:0] a, input logic [7:0] d);
        apb_xfer(1'b1, dcp_pkg::APB_CMD, {20'h0, 1'b1, a, d}, rd);
    endtask

    // stat holds the byte two cycles after the command is taken
    task automatic blk_rd(input logic [2:0] a, output logic [7:0] q);
        logic [31:0] s;
        apb_xfer(1'b1, dcp_pkg::APB_CMD, {20'h0, 1'b0, a, 8'h00}, s);
        repeat (2) @(posedge pclk);
        apb_xfer(1'b0, dcp_pkg::APB_STAT, 32'h0, s);
        q = s[7:0];
    endtask

    task automatic ctl(input logic [31:0] v);
        apb_xfer(1'b1, dcp_pkg::APB_CTRL, v, rd);
    endtask

    task automatic outs(input string n, input logic [2:0] e);
        apb_xfer(1'b0, dcp_pkg::APB_STAT, 32'h0, rd);
        chk(n, e, {rd[dcp_pkg::STAT_LEAD], rd[dcp_pkg::STAT_LAG],
                   rd[dcp_pkg::STAT_IRQ_SEEN]});
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_enable = 1'b0;
        ext_kill = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb_xfer(1'b0, dcp_pkg::APB_CTRL, 32'h0, rd);
        chk("ctrl reset", {27'h0, dcp_pkg::CTL_RST}, rd);
        apb_xfer(1'b1, 8'h10, 32'hffff_ffff, rd);
        apb_xfer(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        chk("slave error", 32'h0, {31'h0, pslverr});
        blk_wr(dcp_pkg::REG_COMPARE, 8'h5a);
        blk_rd(dcp_pkg::REG_COMPARE, b);
        chk("compare value", 32'h5a, {24'h0, b});
        blk_wr(dcp_pkg::REG_PERIOD, 8'h07);
        blk_rd(dcp_pkg::REG_COUNT, b);
        chk("count read", 32'h0, {24'h0, b});
        blk_rd(dcp_pkg::REG_COMPARE, b);
        chk("count copy", 32'h07, {24'h0, b});
        // source runs with enable low: the count must not move
        apb_xfer(1'b1, dcp_pkg::APB_DIV, 32'h3, rd);
        ctl(32'h11);
        blk_wr(dcp_pkg::REG_CONTROL, 8'h01);
        repeat (100) @(posedge pclk);
        apb_xfer(1'b0, dcp_pkg::APB_STAT, 32'h0, rd);
        chk("less than", 32'h0, {31'h0, rd[dcp_pkg::STAT_CMP]});
        blk_wr(dcp_pkg::REG_FUNC, 8'h02);
        repeat (20) @(posedge pclk);
        apb_xfer(1'b0, dcp_pkg::APB_STAT, 32'h0, rd);
        chk("less or equal", 32'h1, {31'h0, rd[dcp_pkg::STAT_CMP]});
        blk_wr(dcp_pkg::REG_CONTROL, 8'h00);
        blk_rd(dcp_pkg::REG_COUNT, b);
        blk_rd(dcp_pkg::REG_COMPARE, b);
        chk("held count", 32'h07, {24'h0, b});
        ext_enable <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ctl((i == 4) ? 32'h11 : 32'h13);
            blk_wr(dcp_pkg::REG_FUNC, {3'h0, FUNCS[i]});
            blk_wr(dcp_pkg::REG_COMPARE, 8'h04);
            blk_wr(dcp_pkg::REG_CONTROL, 8'h01);
            seen = 4'h0;
            repeat (40) begin
                apb_xfer(1'b0, dcp_pkg::APB_STAT, 32'h0, rd);
                seen |= {rd[dcp_pkg::STAT_CMP], !rd[dcp_pkg::STAT_CMP],
                         rd[dcp_pkg::STAT_TC], rd[dcp_pkg::STAT_IRQ_SEEN]};
            end
            blk_wr(dcp_pkg::REG_CONTROL, 8'h00);
            chk("compare tc irq", 32'hf, {28'h0, seen});
        end
        blk_rd(dcp_pkg::REG_COUNT, b);
        blk_rd(dcp_pkg::REG_COMPARE, b);
        chk("count range", 32'h1, {31'h0, b <= 8'h07});
        // dead-band restart: kill, disabled, period, release, enable
        ctl(32'h15);
        blk_wr(dcp_pkg::REG_FUNC, 8'h04);
        blk_wr(dcp_pkg::REG_PERIOD, 8'h02);
        ctl(32'h11);
        blk_wr(dcp_pkg::REG_CONTROL, 8'h01);
        repeat (60) @(posedge pclk);
        ctl(32'h19);
        outs("lead early", 3'b000);
        repeat (60) @(posedge pclk);
        outs("lead after rise", 3'b101);
        ctl(32'h11);
        repeat (60) @(posedge pclk);
        outs("lag after fall", 3'b010);
        ctl(32'h15);
        repeat (4) @(posedge pclk);
        outs("link kill", 3'b000);
        ctl(32'h11);
        ext_kill <= 1'b1;
        blk_wr(dcp_pkg::REG_FUNC, 8'h14);
        repeat (8) @(posedge pclk);
        outs("pin kill", 3'b000);
        ext_kill <= 1'b0;
        report_and_stop();
    end
endmodule
